// File: core/bcz_top.sv
/*
 * Bargraph colour zone selector: APB register file, colour menu driven by
 * program/up/down buttons, dim and lock rear contacts, zone colour output.
 * Assumes buttons are clean single-cycle-or-longer levels from the panel
 * (synchronised here, edge detected); rear contacts are active low pins.
 */
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - The whole bar shows one colour and switches entirely on a zone change.
// - Below the lowest setpoint the separately stored below-all colour shows.
// - Each setpoint owns a colour used above it, whatever the setpoint order.
// - On equal setpoint values the higher-numbered setpoint's colour wins.
// - A colour setting is green, orange or red, stepped by up and down.
// - The menu goes below-all, then setpoints one to four, then exits.
// - After the first step the display alternates label and stored value.
// - While the dim contact is low the brightness output is halved.
// - While the lock contact is low settings may be viewed but not changed.
// - The menu opens only with a tricolour bar, after relay programming.
module bcz_top #(
	parameter int TOGGLE_CYC = bcz_pkg::BCZ_TOGGLE_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        relay_prog_done,
	input  wire logic        btn_prog,
	input  wire logic        btn_up,
	input  wire logic        btn_down,
	input  wire logic        dim_n,
	input  wire logic        lock_n,
	output var  logic [1:0]  bar_colour,
	output var  logic [7:0]  brightness,
	output var  logic        menu_active,
	output var  logic [2:0]  menu_step,
	output var  logic        show_label
);
	import bcz_pkg::*;

	typedef enum logic [5:0] {
		ST_RUN   = 6'h01,
		ST_BELOW = 6'h02,
		ST_C1    = 6'h04,
		ST_C2    = 6'h08,
		ST_C3    = 6'h10,
		ST_C4    = 6'h20
	} bcz_menu_type;

	localparam int TW = $clog2(TOGGLE_CYC + 1);

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [BCZ_VAL_W-1:0] sp_reg [4];
	logic [BCZ_VAL_W-1:0] sp_next [4];
	logic [BCZ_VAL_W-1:0] reading_reg, reading_next;
	logic [9:0]           colours_reg, colours_next;
	logic [7:0]           bright_reg, bright_next;
	logic                 tri_reg, tri_next;
	logic [31:0]          prdata_reg, prdata_next;
	bcz_menu_type         menu_reg, menu_next;
	logic [TW-1:0]        tmr_reg, tmr_next;
	logic                 lbl_reg, lbl_next;

	// Two-flop synchronisers for panel pins, then edge memory
	logic [4:0] sync1_reg, sync2_reg, prev_reg;
	logic [4:0] pins;
	logic       prog_rise, up_rise, down_rise, dim_on, lock_on;

	assign pins = {lock_n, dim_n, btn_down, btn_up, btn_prog};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 5'h18;
			sync2_reg <= 5'h18;
			prev_reg <= 5'h18;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign prog_rise = sync2_reg[0] & ~prev_reg[0];
	assign up_rise = sync2_reg[1] & ~prev_reg[1];
	assign down_rise = sync2_reg[2] & ~prev_reg[2];
	assign dim_on = ~sync2_reg[3];
	assign lock_on = ~sync2_reg[4];

	////////////////////////////////////////////////////////////////////////
	// Colour stepping within green, orange, red
	function automatic logic [1:0] col_step(input logic [1:0] c,
		input logic up);
		logic [1:0] r;
		r = c;
		if (up) begin
			r = (c == BCZ_RED) ? BCZ_GREEN : 2'(c + 2'h1);
		end else begin
			r = (c == BCZ_GREEN) ? BCZ_RED : 2'(c - 2'h1);
		end
		return r;
	endfunction

	// Field index that the menu currently edits
	function automatic int menu_idx(input bcz_menu_type m);
		int k;
		k = 0;
		unique case (m)
			ST_BELOW: k = 0;
			ST_C1:    k = 1;
			ST_C2:    k = 2;
			ST_C3:    k = 3;
			ST_C4:    k = 4;
			default:  k = 0;
		endcase
		return k;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB access, menu sequencing and colour editing
	logic wr_acc;
	logic rd_acc;
	logic map_hit;

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;

	always_comb begin
		map_hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
		sp_next = sp_reg;
		reading_next = reading_reg;
		colours_next = colours_reg;
		bright_next = bright_reg;
		tri_next = tri_reg;
		prdata_next = prdata_reg;
		menu_next = menu_reg;
		tmr_next = tmr_reg;
		lbl_next = lbl_reg;
		// Register writes
		if (wr_acc && map_hit) begin
			unique case (paddr)
				BCZ_OFS_SP1, BCZ_OFS_SP2, BCZ_OFS_SP3, BCZ_OFS_SP4: begin
					if (!lock_on) begin
						sp_next[paddr[3:2]] = pwdata[BCZ_VAL_W-1:0];
					end
				end
				BCZ_OFS_READING: reading_next = pwdata[BCZ_VAL_W-1:0];
				BCZ_OFS_COLOURS: begin
					if (!lock_on) begin
						for (int i = 0; i < 5; i++) begin
							if (pwdata[2*i +: 2] != 2'h3) begin
								colours_next[2*i +: 2] = pwdata[2*i +: 2];
							end
						end
					end
				end
				BCZ_OFS_CTRL: begin
					if (!lock_on) begin
						bright_next = pwdata[BCZ_CTRL_BRIGHT_POS +:
							BCZ_CTRL_BRIGHT_W];
						tri_next = pwdata[BCZ_CTRL_TRI_POS];
					end
				end
				default: ;
			endcase
		end
		// Read data captured in setup phase
		if (rd_acc) begin
			prdata_next = 32'h0;
			unique case (paddr)
				BCZ_OFS_SP1, BCZ_OFS_SP2, BCZ_OFS_SP3, BCZ_OFS_SP4:
					prdata_next[BCZ_VAL_W-1:0] = sp_reg[paddr[3:2]];
				BCZ_OFS_READING: prdata_next[BCZ_VAL_W-1:0] = reading_reg;
				BCZ_OFS_COLOURS: prdata_next[9:0] = colours_reg;
				BCZ_OFS_CTRL: begin
					prdata_next[7:0] = bright_reg;
					prdata_next[BCZ_CTRL_TRI_POS] = tri_reg;
				end
				BCZ_OFS_STATUS: prdata_next[12:0] = {lock_on, dim_on,
					bar_colour, lbl_reg, menu_reg, 2'h0};
				default: ;
			endcase
		end
		// Menu: entry after relay programming only with tricolour bar
		unique case (menu_reg)
			ST_RUN: begin
				if (relay_prog_done && tri_reg) begin
					menu_next = ST_BELOW;
				end
			end
			default: begin
				if (up_rise ^ down_rise) begin
					if (!lock_on) begin
						colours_next[2*menu_idx(menu_reg) +: 2] = col_step(
							colours_reg[2*menu_idx(menu_reg) +: 2],
							up_rise);
					end
				end
				if (prog_rise) begin
					unique case (menu_reg)
						ST_BELOW: menu_next = ST_C1;
						ST_C1:    menu_next = ST_C2;
						ST_C2:    menu_next = ST_C3;
						ST_C3:    menu_next = ST_C4;
						default:  menu_next = ST_RUN;
					endcase
				end
			end
		endcase
		// Label/value alternation from the second step on
		if (menu_next != menu_reg || menu_reg == ST_RUN
			|| menu_reg == ST_BELOW) begin
			tmr_next = '0;
			lbl_next = (menu_next != ST_RUN && menu_next != ST_BELOW);
		end else if (tmr_reg == TW'(TOGGLE_CYC - 1)) begin
			tmr_next = '0;
			lbl_next = ~lbl_reg;
		end else begin
			tmr_next = tmr_reg + TW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				sp_reg[i] <= BCZ_SP_RST;
			end
			reading_reg <= BCZ_SP_RST;
			colours_reg <= BCZ_COLOURS_RST;
			bright_reg <= BCZ_BRIGHT_RST;
			tri_reg <= 1'b1;
			prdata_reg <= 32'h0;
			menu_reg <= ST_RUN;
			tmr_reg <= '0;
			lbl_reg <= 1'b0;
		end else begin
			sp_reg <= sp_next;
			reading_reg <= reading_next;
			colours_reg <= colours_next;
			bright_reg <= bright_next;
			tri_reg <= tri_next;
			prdata_reg <= prdata_next;
			menu_reg <= menu_next;
			tmr_reg <= tmr_next;
			lbl_reg <= lbl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	logic [7:0] bright_out_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bright_out_reg <= 8'h0;
		end else begin
			bright_out_reg <= dim_on ? {1'b0, bright_reg[7:1]} : bright_reg;
		end
	end

	bcz_zone_pick #(.VAL_W(BCZ_VAL_W)) u_pick (
		.pclk      (pclk),
		.presetn   (presetn),
		.reading   (reading_reg),
		.setpoints ({sp_reg[3], sp_reg[2], sp_reg[1], sp_reg[0]}),
		.colours   (colours_reg),
		.colour    (bar_colour)
	);

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~map_hit;
	assign brightness = bright_out_reg;
	assign menu_active = (menu_reg != ST_RUN);
	assign menu_step = 3'(menu_idx(menu_reg));
	assign show_label = lbl_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_prog_last;
		menu_reg == ST_C4 && prog_rise;
	endsequence

	AST_MENU_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
		s_prog_last |=> menu_reg == ST_RUN) else $error("menu did not exit");
	AST_MENU_ADV: assert property (@(posedge pclk) disable iff (!presetn)
		menu_reg == ST_BELOW && prog_rise |=> menu_reg == ST_C1)
		else $error("menu did not advance");
	AST_MENU_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
		menu_reg == ST_RUN && relay_prog_done && !tri_reg |=>
		menu_reg == ST_RUN) else $error("menu entered on mono bar");
	AST_DIM_HALF: assert property (@(posedge pclk) disable iff (!presetn)
		dim_on && $stable(bright_reg)
		|=> brightness == ($past(bright_reg) >> 1))
		else $error("dim did not halve");
	AST_LOCK_COL: assert property (@(posedge pclk) disable iff (!presetn)
		lock_on |=> colours_reg == $past(colours_reg))
		else $error("colour changed while locked");
	AST_COL_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
		colours_reg[1:0] != 2'h3 && colours_reg[3:2] != 2'h3
		&& colours_reg[5:4] != 2'h3 && colours_reg[7:6] != 2'h3
		&& colours_reg[9:8] != 2'h3) else $error("illegal colour");
	AST_LABEL_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		menu_reg == ST_BELOW |-> !lbl_reg) else $error("label on first step");
	AST_BELOW_ALL: assert property (@(posedge pclk) disable iff (!presetn)
		$signed(reading_reg) <= $signed(sp_reg[0])
		&& $signed(reading_reg) <= $signed(sp_reg[1])
		&& $signed(reading_reg) <= $signed(sp_reg[2])
		&& $signed(reading_reg) <= $signed(sp_reg[3])
		&& $stable(reading_reg) && $stable(colours_reg)
		|=> bar_colour == $past(colours_reg[1:0]))
		else $error("below-all colour not shown");
	AST_TOP_WINS: assert property (@(posedge pclk) disable iff (!presetn)
		$signed(reading_reg) > $signed(sp_reg[3])
		&& sp_reg[3] == sp_reg[0] && sp_reg[3] == sp_reg[1]
		&& sp_reg[3] == sp_reg[2] && $stable(colours_reg)
		|=> bar_colour == $past(colours_reg[9:8]))
		else $error("tie not resolved to setpoint four");

endmodule

`default_nettype wire

// File: core/bcz_zone_pick.sv
/*
 * Zone colour picker: chooses the single bar colour from the reading,
 * the four setpoints and the five stored colours.
 * Assumes all inputs are on the pclk domain; output is registered.
 */
`timescale 1ns/1ns
`default_nettype none

module bcz_zone_pick #(
	parameter int VAL_W = 16
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic signed [VAL_W-1:0] reading,
	input  wire logic [4*VAL_W-1:0]      setpoints,
	input  wire logic [9:0]              colours,
	output var  logic [1:0]              colour
);
	import bcz_pkg::*;

	logic [1:0] colour_reg;
	logic [1:0] colour_next;

	////////////////////////////////////////////////////////////////////////
	// Largest exceeded setpoint; later index wins on equal value
	always_comb begin
		logic                    found;
		logic signed [VAL_W-1:0] best;
		logic signed [VAL_W-1:0] sp;
		found = 1'b0;
		best = '0;
		sp = '0;
		colour_next = colours[BCZ_COL_BELOW_POS +: 2];
		for (int i = 0; i < 4; i++) begin
			sp = setpoints[i*VAL_W +: VAL_W];
			if (reading > sp && (!found || sp >= best)) begin
				found = 1'b1;
				best = sp;
				colour_next = colours[BCZ_COL_SP_POS + 2*i +: 2];
			end
		end
	end

	// One colour for the whole bar, switched at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			colour_reg <= 2'h0;
		end else begin
			colour_reg <= colour_next;
		end
	end

	assign colour = colour_reg;

	AST_ONE_COLOUR: assert property (@(posedge pclk) disable iff (!presetn)
		colour != 2'h3) else $error("bar colour code illegal");

endmodule

`default_nettype wire

// File: pkg/bcz_pkg.sv
/*
 * Package for the bargraph colour zone selector: register map, field
 * layout, colour codes and timing counts.
 * Assumes a 100 MHz pclk and a 32-bit APB slave.
 */
package bcz_pkg;

	// Colour codes of the bar
	typedef enum logic [1:0] {
		BCZ_GREEN  = 2'h0,
		BCZ_ORANGE = 2'h1,
		BCZ_RED    = 2'h2
	} bcz_colour_type;

	// Register byte offsets
	localparam logic [11:0] BCZ_OFS_SP1     = 12'h000;
	localparam logic [11:0] BCZ_OFS_SP2     = 12'h004;
	localparam logic [11:0] BCZ_OFS_SP3     = 12'h008;
	localparam logic [11:0] BCZ_OFS_SP4     = 12'h00c;
	localparam logic [11:0] BCZ_OFS_READING = 12'h010;
	localparam logic [11:0] BCZ_OFS_COLOURS = 12'h014;
	localparam logic [11:0] BCZ_OFS_CTRL    = 12'h018;
	localparam logic [11:0] BCZ_OFS_STATUS  = 12'h01c;

	// Value width of setpoints and reading (signed counts)
	localparam int BCZ_VAL_W = 16;

	// Colours register: five 2-bit fields, below-all then setpoints 1..4
	localparam int BCZ_COL_BELOW_POS = 0;
	localparam int BCZ_COL_SP_POS    = 2;

	// Control register fields
	localparam int BCZ_CTRL_BRIGHT_POS = 0;
	localparam int BCZ_CTRL_BRIGHT_W   = 8;
	localparam int BCZ_CTRL_TRI_POS    = 8;

	// Reset values
	localparam logic [BCZ_VAL_W-1:0] BCZ_SP_RST     = 16'h0000;
	localparam logic [9:0]           BCZ_COLOURS_RST = 10'h000;
	localparam logic [7:0]           BCZ_BRIGHT_RST  = 8'hff;

	// Menu label/value alternation, 500 ms each phase
	localparam int BCZ_CLK_MHZ     = 100;
	localparam int BCZ_TOGGLE_MS   = 500;
	localparam int BCZ_TOGGLE_CYC  = BCZ_TOGGLE_MS * 1000 * BCZ_CLK_MHZ;

endpackage

// File: verification/bcz_panel_model.sv
/* Operator panel model: pushbuttons and the two rear contacts.
   Assumes the bench asks for presses at rising pclk edges. */
`timescale 1ns/1ns
`default_nettype none
module bcz_panel_model (
	input  wire logic       pclk,
	input  wire logic [2:0] press,
	input  wire logic       dim_on,
	input  wire logic       lock_on,
	output var  logic       btn_prog,
	output var  logic       btn_up,
	output var  logic       btn_down,
	output var  logic       dim_n,
	output var  logic       lock_n
);
	logic [2:0] held = 3'h0;
	int         cnt = 0;
	// A press holds its buttons for seven cycles, then lets go
	always @(posedge pclk) begin
		if (press != 3'h0) begin
			held <= press;
			cnt <= 6;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else begin
			held <= 3'h0;
		end
	end
	// Button levels and contacts pulled to common ground when closed
	assign btn_prog = held[0];
	assign btn_up = held[1];
	assign btn_down = held[2];
	assign dim_n = !dim_on;
	assign lock_n = !lock_on;
endmodule
`default_nettype wire

// File: verification/bcz_top_test.sv
/* Bench for bcz_top: integer zone model, APB tasks, menu walk, dim, lock.
   Assumes bcz_panel_model drives the buttons and rear contacts. */
`timescale 1ns/1ns
`default_nettype none
module bcz_top_test;
	import bcz_pkg::*;
	localparam int TC = 8;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        relay_prog_done = 1'b0;
	logic [2:0]  press = 3'h0;
	logic        dim_on = 1'b0;
	logic        lock_on = 1'b0;
	logic [31:0] prdata, rd;
	logic [7:0]  brightness, b;
	logic [2:0]  menu_step;
	logic [1:0]  bar_colour;
	logic        pready, pslverr, perr, menu_active, show_label, prev;
	logic        btn_prog, btn_up, btn_down, dim_n, lock_n;
	int          err_count = 0;
	int          cmp_count = 0;
	int          sp[4], col[5], rdg, i, k, s, n;
	// Clock of 10 ns
	initial begin
		forever #5 pclk = ~pclk;
	end
	bcz_top #(.TOGGLE_CYC(TC)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .relay_prog_done(relay_prog_done),
		.btn_prog(btn_prog), .btn_up(btn_up), .btn_down(btn_down),
		.dim_n(dim_n), .lock_n(lock_n), .bar_colour(bar_colour),
		.brightness(brightness), .menu_active(menu_active),
		.menu_step(menu_step), .show_label(show_label));
	bcz_panel_model panel (.pclk(pclk), .press(press), .dim_on(dim_on),
		.lock_on(lock_on), .btn_prog(btn_prog), .btn_up(btn_up),
		.btn_down(btn_down), .dim_n(dim_n), .lock_n(lock_n));
	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic complete_run();
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int w;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 20);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w >= 20) begin
			err_count++;
			complete_run();
		end
	endtask
	// Wait whole cycles, then settle at the falling edge
	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
		@(negedge pclk);
	endtask
	// Ask the panel for a press, then let the menu react
	task automatic push(input logic [2:0] p);
		@(posedge pclk);
		press <= p;
		@(posedge pclk);
		press <= 3'h0;
		wt(10);
	endtask
	// Pulse the end of relay programming
	task automatic relay_done();
		@(posedge pclk);
		relay_prog_done <= 1'b1;
		@(posedge pclk);
		relay_prog_done <= 1'b0;
		wt(3);
	endtask
	// Expected colour: largest exceeded setpoint, ties to higher number
	function automatic int zone();
		int c, best;
		c = col[0];
		best = -100000;
		for (int j = 0; j < 4; j++)
			if (rdg > sp[j] && sp[j] >= best) begin
				c = col[j+1];
				best = sp[j];
			end
		return c;
	endfunction
	// Stored colours packed as in the colours register
	function automatic logic [31:0] colw();
		colw = 32'h0;
		for (int j = 0; j < 5; j++)
			colw = colw | (32'(col[j]) << (2*j));
	endfunction
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'hdd49));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wt(2);
		chk(brightness, 32'hff);
		apb(1'b0, BCZ_OFS_CTRL, 32'h0);
		chk(rd, 32'h1ff);
		apb(1'b0, 12'h020, 32'h0);
		chk(perr, 32'h1);
		for (k = 0; k < 40; k++) begin
			for (i = 0; i < 5; i++)
				col[i] = $urandom_range(2);
			apb(1'b1, BCZ_OFS_COLOURS, colw());
			for (i = 0; i < 4; i++) begin
				sp[i] = int'($urandom_range(8)) - 4;
				apb(1'b1, BCZ_OFS_SP1 + 12'(4*i), 32'(sp[i]) & 32'hffff);
			end
			rdg = int'($urandom_range(10)) - 5;
			apb(1'b1, BCZ_OFS_READING, 32'(rdg) & 32'hffff);
			wt(3);
			chk(bar_colour, 32'(zone()));
		end
		apb(1'b1, BCZ_OFS_COLOURS, 32'h3ff);
		apb(1'b0, BCZ_OFS_COLOURS, 32'h0);
		chk(rd, colw());
		b = 8'($urandom_range(255));
		apb(1'b1, BCZ_OFS_CTRL, {23'h0, 1'b1, b});
		@(posedge pclk);
		dim_on <= 1'b1;
		wt(6);
		chk(brightness, b >> 1);
		@(posedge pclk);
		dim_on <= 1'b0;
		lock_on <= 1'b1;
		wt(6);
		chk(brightness, b);
		apb(1'b1, BCZ_OFS_SP1, 32'h7);
		apb(1'b0, BCZ_OFS_SP1, 32'h0);
		chk(rd, 32'(sp[0]) & 32'hffff);
		// Status: lock seen, dim clear, zone colour, run state one-hot
		apb(1'b0, BCZ_OFS_STATUS, 32'h0);
		chk(rd, 32'h1004 | (32'(zone()) << 9));
		relay_done();
		chk(menu_active, 32'h1);
		push(3'h2);
		apb(1'b0, BCZ_OFS_COLOURS, 32'h0);
		chk(rd, colw());
		@(posedge pclk);
		lock_on <= 1'b0;
		wt(6);
		push(3'h6);
		for (s = 0; s < 5; s++) begin
			chk(menu_step, 32'(s));
			if (s == 0)
				chk(show_label, 32'h0);
			push((s % 2 == 0) ? 3'h2 : 3'h4);
			col[s] = (s % 2 == 0) ? (col[s] + 1) % 3 : (col[s] + 2) % 3;
			apb(1'b0, BCZ_OFS_COLOURS, 32'h0);
			chk(rd, colw());
			if (s > 0) begin
				wt(0);
				n = 0;
				prev = show_label;
				repeat (4*TC) begin
					@(negedge pclk);
					if (show_label !== prev)
						n++;
					prev = show_label;
				end
				chk(n >= 3 && n <= 5, 32'h1);
			end
			push(3'h1);
		end
		chk(menu_active, 32'h0);
		chk(bar_colour, 32'(zone()));
		// Mid-run reset: outputs clear, then defaults come back
		@(posedge pclk);
		presetn <= 1'b0;
		wt(2);
		chk(brightness, 32'h0);
		chk(menu_active, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		wt(2);
		chk(brightness, 32'hff);
		chk(bar_colour, 32'h0);
		apb(1'b1, BCZ_OFS_CTRL, 32'h0ff);
		relay_done();
		chk(menu_active, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
